/* File: rtl/ulac_pkg.sv */
// shared constants and types for the uplink attenuation compensator
package ulac_pkg;

   // all levels in signed 0.1 dB units
   localparam int LVL_W = 16;

   // register offsets (word index on the plain port)
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_RANGE   = 4'h1;
   localparam logic [3:0] ADDR_RATIO   = 4'h2;
   localparam logic [3:0] ADDR_STEP    = 4'h3;
   localparam logic [3:0] ADDR_SLEW    = 4'h4;
   localparam logic [3:0] ADDR_SAMPLE  = 4'h5;
   localparam logic [3:0] ADDR_HYST    = 4'h6;
   localparam logic [3:0] ADDR_MANUAL  = 4'h7;
   localparam logic [3:0] ADDR_CSKY    = 4'h8;
   localparam logic [3:0] ADDR_CSOFS   = 4'h9;
   localparam logic [3:0] ADDR_CALOFS  = 4'hA;
   localparam logic [3:0] ADDR_ATTEN   = 4'hB;
   localparam logic [3:0] ADDR_DELTA   = 4'hC;

   // control register field positions
   localparam int CTRL_MODE_LSB = 0;   // 2 bits
   localparam int CTRL_SRC_BIT  = 2;
   localparam int CTRL_SLEW_BIT = 3;
   localparam int CTRL_SCIN_BIT = 4;
   localparam int CTRL_CAL_BIT  = 5;   // write 1: calibrate now

   // limits and resets, in tenths: 0.1 dB, 0.1 s or 0.1 ratio
   localparam logic [15:0] RANGE_MIN   = 16'h0014;  // 2 dB
   localparam logic [15:0] RANGE_MAX   = 16'h012C;  // 30 dB
   localparam logic [15:0] RANGE_RST   = 16'h0064;  // 10 dB
   localparam logic [15:0] RATIO_MIN   = 16'h0001;  // 0.1
   localparam logic [15:0] RATIO_MAX   = 16'h0064;  // 10
   localparam logic [15:0] RATIO_RST   = 16'h000A;  // 1.0
   localparam logic [15:0] HYST_MAX    = 16'h001E;  // 3.0 dB
   localparam logic [15:0] SAMPLE_MIN  = 16'h0002;  // 0.2 s
   localparam logic [15:0] SAMPLE_MAX  = 16'h0064;  // 10 s
   localparam logic [15:0] SAMPLE_RST  = 16'h0064;
   localparam logic [15:0] TENTH_DB    = 16'h0001;

   // step size and slew rate code resets
   localparam logic [2:0] STEP_RST = 3'h0;
   localparam logic [2:0] SLEW_RST = 3'h0;

   // timing
   localparam int CLK_HZ          = 100_000_000;
   localparam int TICK_MS         = 5;
   localparam int TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_TENTH = 20;   // 100 ms of 5 ms ticks
   localparam int TICKS_PER_SEC   = 200;

   typedef enum logic [3:0] {
      MODE_OFF    = 4'b0001,
      MODE_MANUAL = 4'b0010,
      MODE_AUTO   = 4'b0100,
      MODE_COMP   = 4'b1000
   } ulac_mode_t;

   typedef struct packed {
      logic [15:0] addr_pad;
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ulac_bus_t;

   typedef struct packed {
      ulac_mode_t          mode;
      logic                src_int;
      logic                slew_en;
      logic                scin_en;
      logic [15:0]         range;
      logic [15:0]         ratio;
      logic [2:0]          step_code;
      logic [2:0]          slew_code;
      logic [15:0]         sample;
      logic [15:0]         hyst;
      logic signed [15:0]  manual;
      logic signed [15:0]  csky;
      logic signed [15:0]  csofs;
      logic signed [15:0]  cal_ofs;
      logic signed [31:0]  acc;
      logic [15:0]         acc_n;
      logic [15:0]         per_cnt;
      logic [15:0]         slew_cnt;
      logic [7:0]          sec_cnt;
      logic [23:0]         tick_cnt;
      logic signed [15:0]  target;
      logic signed [15:0]  atten;
      logic signed [15:0]  delta;
      logic                bypass;
      logic [15:0]         rdata;
   } ulac_state_t;

endpackage : ulac_pkg

/* File: rtl/ulac_core.sv */
// uplink attenuation compensator: averaging, calculation and output
// Summary of operation
// - modes: automatic, manual, comparison (plus off)
// - automatic tracks selected beacon source
// - manual applies user attenuation value
// - calibration stores pilot minus beacon offset
// - comparison delta: offset minus (pilot minus beacon)
// - equal fades leave attenuation unchanged
// - shared range 2 to 30 dB, default 10
// - ratio 0.1 to 10 per dB drop
// - step quantised: 0.1,0.2,0.5,1,2 dB
// - slew 1 dB per 10/20/50/100 s
// - slew off by default, apply at once
// - average beacon over 0.2 to 10 s
// - no removal until fade exceeds hysteresis
// - scintillation updates every 10 ms
// - scintillation walks every 0.1 dB step
// - source select: beacon or pilot input
// - manual starts at last auto or max
// - off mode bypasses, default off-line
`timescale 1ns/100ps
module ulac_core
   import ulac_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)(
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               sys_rst,
   // register port
   input  wire logic [3:0]         reg_addr,
   input  wire logic [15:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [15:0]        reg_rdata,
   // level inputs, signed 0.1 dB
   input  wire logic signed [15:0] ext_level,
   input  wire logic signed [15:0] int_level,
   // attenuator drive
   output logic signed [15:0]      atten_out,
   output logic                    atten_bypass
);

   initial
   begin
      if (TICK_CYCLES < 2 || TICK_CYCLES > 16_000_000)
         $error("ulac_core: TICK_CYCLES out of range");
   end

   ulac_state_t s_r;
   ulac_state_t s_nxt;

   function automatic logic [15:0] step_of(input logic [2:0] c);
      unique case (c)
         3'h1:    step_of = 16'h0002;
         3'h2:    step_of = 16'h0005;
         3'h3:    step_of = 16'h000A;
         3'h4:    step_of = 16'h0014;
         default: step_of = 16'h0001;
      endcase
   endfunction : step_of

   // ticks of 5 ms per 0.1 dB move under slew
   function automatic logic [15:0] slew_of(input logic [2:0] c);
      unique case (c)
         3'h1:    slew_of = 16'd400;
         3'h2:    slew_of = 16'd1000;
         3'h3:    slew_of = 16'd2000;
         default: slew_of = 16'd200;
      endcase
   endfunction : slew_of

   function automatic logic [15:0] clampu(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clampu

   logic signed [15:0] beacon_now;
   logic signed [15:0] pilot_now;
   logic               tick;
   logic signed [15:0] avg;
   logic signed [15:0] fade;
   logic signed [31:0] prod;
   logic signed [15:0] corr;
   logic signed [15:0] quant;
   logic [15:0]        stp;
   logic               per_done;
   logic               move;
   ulac_mode_t         new_mode;
   logic signed [15:0] cal_beacon;
   logic signed [15:0] cal_pilot;

   always_comb
   begin
      s_nxt = s_r;
      new_mode = s_r.mode;
      // calibration follows the source and mode being written, not the old
      cal_pilot = reg_wdata[CTRL_SRC_BIT] ? int_level : ext_level;
      if (reg_wdata[CTRL_MODE_LSB +: 2] == 2'h3)
         cal_beacon = reg_wdata[CTRL_SRC_BIT] ? ext_level : int_level;
      else
         cal_beacon = reg_wdata[CTRL_SRC_BIT] ? int_level : ext_level;
      beacon_now = s_r.src_int ? ext_level : int_level;
      pilot_now  = s_r.src_int ? int_level : ext_level;
      if (s_r.mode != MODE_COMP)
         beacon_now = s_r.src_int ? int_level : ext_level;
      tick = (s_r.tick_cnt == 24'(TICK_CYCLES - 1));
      s_nxt.tick_cnt = tick ? 24'h00_0000 : s_r.tick_cnt + 24'h00_0001;
      avg = 16'(s_r.acc / $signed({16'h0000, s_r.acc_n}));
      per_done = 1'b0;

      // running sum per tick, period in tenths of a second
      if (tick)
      begin
         if (s_r.mode == MODE_COMP)
            s_nxt.acc = s_r.acc + 32'(pilot_now - beacon_now - s_r.cal_ofs);
         else
            s_nxt.acc = s_r.acc + 32'(beacon_now);
         s_nxt.acc_n = s_r.acc_n + 16'h0001;
         if (s_r.sec_cnt == 8'(TICKS_PER_TENTH - 1))
         begin
            s_nxt.sec_cnt = 8'h00;
            s_nxt.per_cnt = s_r.per_cnt + 16'h0001;
         end
         else
            s_nxt.sec_cnt = s_r.sec_cnt + 8'h01;
      end
      // scintillation recalculates on every second 5 ms tick
      if (s_r.acc_n != 16'h0000 &&
          ((s_r.scin_en && tick) || (s_r.per_cnt >= s_r.sample)))
         per_done = 1'b1;

      // fade measured against clear sky level outside comparison mode
      if (s_r.mode == MODE_COMP)
         fade = -avg;
      else
         fade = s_r.csky + s_r.csofs - avg;
      // equal fades cancel inside the comparison delta
      s_nxt.delta = per_done ? fade : s_r.delta;
      if (fade <= $signed(s_r.hyst))
         fade = 16'sh0000;
      prod = fade * $signed(s_r.ratio);
      corr = 16'(prod / 32'sd10);
      if (corr < 16'sh0000)
         corr = 16'sh0000;
      if (corr > $signed(s_r.range))
         corr = $signed(s_r.range);
      stp = step_of(s_r.step_code);
      quant = corr - 16'(corr % $signed(stp));
      // max attenuation at clear sky, reduced by correction
      if (per_done)
      begin
         s_nxt.target = $signed(s_r.range) - quant;
         s_nxt.acc = 32'sh0000_0000;
         s_nxt.acc_n = 16'h0000;
         s_nxt.per_cnt = 16'h0000;
         s_nxt.sec_cnt = 8'h00;
      end

      // output movement
      move = 1'b0;
      if (s_r.mode == MODE_AUTO || s_r.mode == MODE_COMP)
      begin
         if (s_r.scin_en)
            move = tick;
         else if (s_r.slew_en)
         begin
            if (tick)
            begin
               if (s_r.slew_cnt >= slew_of(s_r.slew_code) - 16'h0001)
               begin
                  s_nxt.slew_cnt = 16'h0000;
                  move = 1'b1;
               end
               else
                  s_nxt.slew_cnt = s_r.slew_cnt + 16'h0001;
            end
         end
         else
            s_nxt.atten = s_r.target;
         if (move && s_r.atten < s_r.target)
            s_nxt.atten = s_r.atten + $signed(TENTH_DB);
         if (move && s_r.atten > s_r.target)
            s_nxt.atten = s_r.atten - $signed(TENTH_DB);
      end
      if (s_r.mode == MODE_MANUAL)
         s_nxt.atten = s_r.manual;
      s_nxt.bypass = (s_r.mode == MODE_OFF);

      // register port
      s_nxt.rdata = 16'h0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            ADDR_CTRL:   s_nxt.rdata = {11'h000, s_r.scin_en, s_r.slew_en,
                                        s_r.src_int, s_r.mode == MODE_AUTO
                                        || s_r.mode == MODE_COMP,
                                        s_r.mode == MODE_MANUAL
                                        || s_r.mode == MODE_COMP};
            ADDR_RANGE:  s_nxt.rdata = s_r.range;
            ADDR_RATIO:  s_nxt.rdata = s_r.ratio;
            ADDR_STEP:   s_nxt.rdata = {13'h0000, s_r.step_code};
            ADDR_SLEW:   s_nxt.rdata = {13'h0000, s_r.slew_code};
            ADDR_SAMPLE: s_nxt.rdata = s_r.sample;
            ADDR_HYST:   s_nxt.rdata = s_r.hyst;
            ADDR_MANUAL: s_nxt.rdata = s_r.manual;
            ADDR_CSKY:   s_nxt.rdata = s_r.csky;
            ADDR_CSOFS:  s_nxt.rdata = s_r.csofs;
            ADDR_CALOFS: s_nxt.rdata = s_r.cal_ofs;
            ADDR_ATTEN:  s_nxt.rdata = s_r.atten;
            ADDR_DELTA:  s_nxt.rdata = s_r.delta;
            default:     s_nxt.rdata = 16'h0000;
         endcase
      end
      if (reg_wr)
      begin
         unique case (reg_addr)
            ADDR_CTRL:
            begin
               // mode code 0 off, 1 manual, 2 auto, 3 comparison
               unique case (reg_wdata[CTRL_MODE_LSB +: 2])
                  2'h1:    new_mode = MODE_MANUAL;
                  2'h2:    new_mode = MODE_AUTO;
                  2'h3:    new_mode = MODE_COMP;
                  default: new_mode = MODE_OFF;
               endcase
               if (new_mode == MODE_MANUAL && s_r.mode != MODE_MANUAL)
                  s_nxt.manual = (s_r.mode == MODE_OFF) ?
                                 $signed(s_r.range) : s_r.atten;
               s_nxt.mode    = new_mode;
               s_nxt.src_int = reg_wdata[CTRL_SRC_BIT];
               s_nxt.slew_en = reg_wdata[CTRL_SLEW_BIT];
               s_nxt.scin_en = reg_wdata[CTRL_SCIN_BIT];
               if (reg_wdata[CTRL_CAL_BIT])
               begin
                  s_nxt.csky    = cal_beacon;
                  s_nxt.cal_ofs = cal_pilot - cal_beacon;
               end
            end
            ADDR_RANGE:  s_nxt.range = clampu(reg_wdata, RANGE_MIN,
                                              RANGE_MAX);
            ADDR_RATIO:  s_nxt.ratio = clampu(reg_wdata, RATIO_MIN,
                                              RATIO_MAX);
            ADDR_STEP:   s_nxt.step_code = (reg_wdata[2:0] > 3'h4) ?
                                           3'h4 : reg_wdata[2:0];
            ADDR_SLEW:   s_nxt.slew_code = {1'b0, reg_wdata[1:0]};
            ADDR_SAMPLE: s_nxt.sample = clampu(reg_wdata, SAMPLE_MIN,
                                               SAMPLE_MAX);
            ADDR_HYST:   s_nxt.hyst = (reg_wdata > HYST_MAX) ?
                                      HYST_MAX : reg_wdata;
            ADDR_MANUAL:
            begin
               // manual value held inside the range
               if ($signed(reg_wdata) < 16'sh0000)
                  s_nxt.manual = 16'sh0000;
               else if ($signed(reg_wdata) > $signed(s_r.range))
                  s_nxt.manual = $signed(s_r.range);
               else
                  s_nxt.manual = $signed(reg_wdata);
            end
            ADDR_CSOFS:  s_nxt.csofs = $signed(reg_wdata);
            default:     s_nxt.csofs = s_r.csofs;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         s_r           <= '0;
         s_r.mode      <= MODE_OFF;
         s_r.range     <= RANGE_RST;
         s_r.ratio     <= RATIO_RST;
         s_r.step_code <= STEP_RST;
         s_r.slew_code <= SLEW_RST;
         s_r.sample    <= SAMPLE_RST;
         s_r.target    <= $signed(RANGE_RST);
         s_r.bypass    <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   assign reg_rdata    = s_r.rdata;
   assign atten_out    = s_r.atten;
   assign atten_bypass = s_r.bypass;

endmodule : ulac_core

/* File: test/ulac_rx_model.sv */
// level receiver model feeding beacon and pilot levels to the compensator
`timescale 1ns/100ps
module ulac_rx_model
   import ulac_pkg::*;
(
   // clock
   input  wire logic               ref_clk,
   // commanded receiver levels
   input  wire logic signed [15:0] ext_cmd,
   input  wire logic signed [15:0] int_cmd,
   // detector outputs
   output logic signed [15:0]      ext_level,
   output logic signed [15:0]      int_level
);
   // detectors refresh on the clock, so a level step lands one cycle late
   always_ff @(posedge ref_clk)
   begin
      ext_level <= ext_cmd;
      int_level <= int_cmd;
   end
endmodule : ulac_rx_model

/* File: test/ulac_core_asserts.sv */
// port assertions for the uplink attenuation compensator
`timescale 1ns/100ps
module ulac_core_asserts
   import ulac_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)(
   // clock and reset
   input wire logic               ref_clk,
   input wire logic               sys_rst,
   // register port
   input wire logic [3:0]         reg_addr,
   input wire logic [15:0]        reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [15:0]        reg_rdata,
   // levels and drive
   input wire logic signed [15:0] ext_level,
   input wire logic signed [15:0] int_level,
   input wire logic signed [15:0] atten_out,
   input wire logic               atten_bypass
);
   logic [1:0]  mode_q;
   logic        scin_q;
   logic [15:0] man_q;
   // mirror control writes so no internal probes are needed
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         mode_q <= 2'h0;
         scin_q <= 1'b0;
      end
      else if (reg_wr && reg_addr == ADDR_CTRL)
      begin
         mode_q <= reg_wdata[1:0];
         scin_q <= reg_wdata[CTRL_SCIN_BIT];
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (reg_wr && reg_addr == ADDR_MANUAL)
         man_q <= reg_wdata;
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   reset_bypass_a: assert property (disable iff (1'b0)
      sys_rst |=> atten_bypass && atten_out == 16'h0000)
      else $error("bypass or zero drive missing after reset");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   off_bypass_a: assert property (mode_q == 2'h0 && $past(mode_q) == 2'h0
      |-> atten_bypass) else $error("off mode not bypassed");
   in_circuit_a: assert property (mode_q != 2'h0 && $past(mode_q) != 2'h0
      |-> !atten_bypass) else $error("active mode left in bypass");
   atten_range_a: assert property (!atten_out[15]
      && atten_out <= RANGE_MAX) else $error("attenuation outside range");
   scin_step_a: assert property (scin_q && mode_q[1] && $stable(mode_q)
      |=> atten_out - $past(atten_out) inside {16'h0000, 16'h0001, 16'hFFFF})
      else $error("scintillation skipped a tenth step");
   manual_apply_a: assert property (reg_wr && reg_addr == ADDR_MANUAL
      && mode_q == 2'h1 && reg_wdata <= RANGE_MIN |-> ##[1:3] atten_out == man_q)
      else $error("manual value not applied");
   atten_readback_a: assert property (reg_rd && reg_addr == ADDR_ATTEN
      |=> reg_rdata == $past(atten_out)) else $error("attenuation readback");
   ctrl_readback_a: assert property (reg_wr && reg_addr == ADDR_CTRL ##1
      reg_rd && reg_addr == ADDR_CTRL
      |=> reg_rdata == ($past(reg_wdata, 2) & 16'h001F))
      else $error("control readback wrong");
endmodule : ulac_core_asserts
bind ulac_core ulac_core_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ext_level(ext_level), .int_level(int_level),
   .atten_out(atten_out), .atten_bypass(atten_bypass));

/* File: test/tb_top.sv */
// self-checking bench for the uplink attenuation compensator
`timescale 1ns/100ps
module tb_top
   import ulac_pkg::*;
;
   localparam int          W = 1000;
   localparam logic [15:0] B = 16'hFE0C;
   logic               ref_clk;
   logic               sys_rst;
   logic [3:0]         reg_addr;
   logic [15:0]        reg_wdata;
   logic               reg_wr;
   logic               reg_rd;
   logic [15:0]        reg_rdata;
   logic signed [15:0] ext_cmd;
   logic signed [15:0] int_cmd;
   logic signed [15:0] ext_level;
   logic signed [15:0] int_level;
   logic signed [15:0] atten_out;
   logic               atten_bypass;
   int                 fail_count;
   int                 compares;
   logic [15:0]        step_exp [5];
   // short tick keeps a 0.2 s sample period at 400 cycles
   ulac_core #(.TICK_CYCLES(10)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ext_level(ext_level), .int_level(int_level),
      .atten_out(atten_out), .atten_bypass(atten_bypass));
   ulac_rx_model rx (
      .ref_clk(ref_clk), .ext_cmd(ext_cmd), .int_cmd(int_cmd),
      .ext_level(ext_level), .int_level(int_level));
   task automatic conclude();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [15:0] e, g);
      compares++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic pause(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : pause
   task automatic settle(input logic [15:0] e);
      pause(W);
      chk("atten", e, atten_out);
   endtask : settle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      // next strobe starts later, so the strobe is never assigned twice
      #1;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("rdata", e, reg_rdata);
   endtask : rd
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      fail_count++;
      conclude();
   end
   initial
   begin
      step_exp = '{16'h004E, 16'h004E, 16'h0050, 16'h0050, 16'h0050};
      sys_rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ext_cmd = B;
      int_cmd = B;
      fail_count = 0;
      compares = 0;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(ADDR_RANGE, RANGE_RST);
      rd(ADDR_RATIO, RATIO_RST);
      rd(ADDR_STEP, {13'h0000, STEP_RST});
      rd(ADDR_SLEW, {13'h0000, SLEW_RST});
      rd(ADDR_SAMPLE, SAMPLE_RST);
      rd(ADDR_CTRL, 16'h0000);
      chk("bypass", 16'h0001, {15'h0000, atten_bypass});
      rd(4'hF, 16'h0000);
      wr(ADDR_CTRL, 16'h003C);
      rd(ADDR_CTRL, 16'h001C);
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_RANGE, 16'h0001);
      rd(ADDR_RANGE, RANGE_MIN);
      wr(ADDR_RANGE, 16'h0190);
      rd(ADDR_RANGE, RANGE_MAX);
      wr(ADDR_RANGE, RANGE_RST);
      $display("test reset done");
      wr(ADDR_CTRL, 16'h0001);
      pause(3);
      chk("atten", RANGE_RST, atten_out);
      chk("bypass", 16'h0000, {15'h0000, atten_bypass});
      wr(ADDR_MANUAL, 16'h0037);
      pause(3);
      rd(ADDR_ATTEN, 16'h0037);
      wr(ADDR_MANUAL, 16'h000F);
      pause(3);
      chk("atten", 16'h000F, atten_out);
      $display("test manual done");
      wr(ADDR_SAMPLE, SAMPLE_MIN);
      wr(ADDR_CTRL, 16'h0026);
      settle(16'h0064);
      rd(ADDR_CSKY, B);
      int_cmd <= B - 16'h001E;
      ext_cmd <= B + 16'h0064;
      settle(16'h0046);
      wr(ADDR_HYST, HYST_MAX);
      settle(16'h0064);
      wr(ADDR_HYST, 16'h001D);
      settle(16'h0046);
      wr(ADDR_HYST, 16'h0000);
      int_cmd <= B - 16'h0016;
      for (int i = 0; i < 5; i++)
      begin
         wr(ADDR_STEP, 16'(i));
         settle(step_exp[i]);
      end
      wr(ADDR_STEP, 16'h0000);
      wr(ADDR_RATIO, 16'h0014);
      settle(16'h0038);
      wr(ADDR_RATIO, RATIO_MAX);
      settle(16'h0000);
      wr(ADDR_RATIO, RATIO_RST);
      settle(16'h004E);
      wr(ADDR_CSOFS, 16'h000A);
      rd(ADDR_CSOFS, 16'h000A);
      settle(16'h0044);
      wr(ADDR_CSOFS, 16'h0000);
      settle(16'h004E);
      wr(ADDR_CTRL, 16'h0001);
      pause(3);
      chk("atten", 16'h004E, atten_out);
      $display("test auto done");
      int_cmd <= B + 16'h00C8;
      ext_cmd <= B;
      pause(2);
      wr(ADDR_CTRL, 16'h0027);
      pause(2);
      rd(ADDR_CALOFS, 16'h00C8);
      settle(16'h0064);
      int_cmd <= B + 16'h00A0;
      ext_cmd <= B - 16'h0028;
      settle(16'h0064);
      int_cmd <= B + 16'h0082;
      settle(16'h0046);
      rd(ADDR_DELTA, 16'h001E);
      $display("test comparison done");
      int_cmd <= B;
      ext_cmd <= B;
      pause(2);
      wr(ADDR_CTRL, 16'h0026);
      settle(16'h0064);
      int_cmd <= B - 16'h001E;
      wr(ADDR_CTRL, 16'h000E);
      pause(W);
      chk("slew", 16'h0001, {15'h0000,
         atten_out === 16'h0064 || atten_out === 16'h0063});
      wr(ADDR_CTRL, 16'h0016);
      pause(150);
      chk("walk", 16'h0001, {15'h0000,
         atten_out < 16'sh0063 && atten_out > 16'sh0046});
      settle(16'h0046);
      wr(ADDR_CTRL, 16'h0000);
      pause(3);
      chk("bypass", 16'h0001, {15'h0000, atten_bypass});
      $display("test slew and scintillation done");
      conclude();
   end
endmodule : tb_top
